// file: hdl/fu_pkg.sv
`default_nettype none
package fu_pkg;
    // register indices on the three address lines
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_LINE   = 3'h1;
    localparam logic [2:0] ADDR_DIV_LO = 3'h2;
    localparam logic [2:0] ADDR_DIV_HI = 3'h3;
    localparam logic [2:0] ADDR_CTRL   = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;

    // control register bit positions; clear bits act and are not stored
    localparam int unsigned CTRL_TX_EN  = 0;
    localparam int unsigned CTRL_RX_EN  = 1;
    localparam int unsigned CTRL_LOOP   = 2;
    localparam int unsigned CTRL_TX_CLR = 3;
    localparam int unsigned CTRL_RX_CLR = 4;
    localparam logic [7:0]  CTRL_KEEP   = 8'h07;

    localparam logic [7:0]  LINE_RST = 8'h03;
    localparam logic [15:0] DIV_RST  = 16'h0001;
    localparam logic [7:0]  CTRL_RST = 8'h03;

    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned RX_ERR_W   = 3;

    localparam logic [3:0] SUB_LAST     = 4'hf;
    localparam logic [3:0] SUB_MID      = 4'h7;
    localparam logic [2:0] MIN_LAST_BIT = 3'h4;
    localparam logic [1:0] LEN_MAX      = 2'h3;

    typedef struct packed {
        logic [2:0] unused;
        logic       par_even;
        logic       par_en;
        logic       two_stop;
        logic [1:0] len;
    } fu_line_cfg_t;

    typedef struct packed {
        logic       brk;
        logic       frame;
        logic       parity;
        logic [7:0] data;
    } fu_rx_entry_t;

    typedef struct packed {
        logic tx_full;
        logic tx_done;
        logic tx_empty;
        logic brk;
        logic frame;
        logic parity;
        logic overrun;
        logic rx_avail;
    } fu_status_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PARITY, TX_STOP
    } fu_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } fu_rx_state_t;
endpackage : fu_pkg
`default_nettype wire

// file: hdl/fu_fifo_mem.sv
`default_nettype none
module fu_fifo_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // read data is registered; a same-cycle write shows one cycle later
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // fu_fifo_mem
`default_nettype wire

// file: hdl/fu_uart.sv
`default_nettype none
module fu_uart #(
    parameter int unsigned FIFO_DEPTH = fu_pkg::FIFO_DEPTH,
    parameter int unsigned AW         = $clog2(FIFO_DEPTH)
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       select_a_high,
    input  wire logic       select_b_high,
    input  wire logic       select_c_low,
    input  wire logic       write_strobe_low,
    input  wire logic       write_strobe_high,
    input  wire logic       read_strobe_low,
    input  wire logic       read_strobe_high,
    input  wire logic [2:0] register_address,
    input  wire logic [7:0] host_data_bus_in,
    output logic      [7:0] host_data_bus_out,
    output logic            host_data_bus_oe,
    output logic            drive_disable_out_n,
    input  wire logic       serial_in,
    output logic            serial_out,
    input  wire logic       receiver_clock_in,
    output logic            baud_out_low
);
    localparam int unsigned RXW = fu_pkg::DATA_W + fu_pkg::RX_ERR_W;

    // host side and registers
    logic                 wr_prev_q, wr_prev_d, rd_prev_q, rd_prev_d;
    logic [2:0]           wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
    logic [7:0]           wr_data_q, wr_data_d, dout_q, dout_d;
    logic                 doe_q, doe_d, drive_disable_out_n_q, drive_disable_out_n_d;
    fu_pkg::fu_line_cfg_t line_q, line_d;
    logic [15:0]          div_q, div_d;
    logic [7:0]           ctrl_q, ctrl_d;
    logic                 ovr_q, ovr_d;
    logic                 sel, wr_act, rd_act, wr_fire, rd_end;
    logic                 tx_push, rx_pop, tx_clr, rx_clr;
    fu_pkg::fu_status_t   st;
    // fifo pointers carry one wrap bit
    logic [AW:0]          txw_q, txw_d, txr_q, txr_d;
    logic [AW:0]          rxw_q, rxw_d, rxr_q, rxr_d;
    logic                 rx_new_q, rx_new_d;
    logic                 tx_empty, tx_full, rx_empty, rx_full;
    logic [7:0]           tx_head;
    logic [RXW-1:0]       rx_head_raw;
    fu_pkg::fu_rx_entry_t rx_head, rx_entry;
    // baud generator
    logic [15:0]          bcnt_q, bcnt_d;
    logic                 tick_q, tick_d, blow_q, blow_d;
    // transmitter
    fu_pkg::fu_tx_state_t tx_st_q, tx_st_d;
    logic [3:0]           tx_sub_q, tx_sub_d;
    logic [2:0]           tx_bit_q, tx_bit_d;
    logic [7:0]           tx_sh_q, tx_sh_d;
    logic                 tx_par_q, tx_par_d, tx_line_q, tx_line_d;
    logic                 tx_stop2_q, tx_stop2_d, serial_out_q, serial_out_d, tx_pop;
    // receiver
    fu_pkg::fu_rx_state_t rx_st_q, rx_st_d;
    logic [3:0]           rx_sub_q, rx_sub_d;
    logic [2:0]           rx_bit_q, rx_bit_d;
    logic [7:0]           rx_sh_q, rx_sh_d, rx_data;
    logic                 rx_perr_q, rx_perr_d, rx_pbit_q, rx_pbit_d;
    logic                 rxc_q, rx_line_q, rx_line_d, rx_tick;
    logic                 rx_push_req, rx_push;
    logic [2:0]           last_bit;
    logic [1:0]           len_gap;

    function automatic logic parity_of(input logic [7:0] d, input logic even);
        parity_of = even ? ^d : ~(^d);
    endfunction

    assign last_bit = fu_pkg::MIN_LAST_BIT + {1'b0, line_q.len};
    assign len_gap  = fu_pkg::LEN_MAX - line_q.len;

    assign sel    = select_a_high & select_b_high & ~select_c_low;
    assign wr_act = sel & (~write_strobe_low | write_strobe_high);
    assign rd_act = sel & (~read_strobe_low | read_strobe_high);
    // write lands at the trailing edge so data is stable all strobe long
    assign wr_fire = wr_prev_q & ~wr_act;
    assign rd_end  = rd_prev_q & ~rd_act;

    assign tx_empty = txw_q == txr_q;
    assign tx_full  = (txw_q[AW] != txr_q[AW])
                    && (txw_q[AW-1:0] == txr_q[AW-1:0]);
    // an entry just written is hidden until its head fetch has landed
    assign rx_empty = (rxw_q == rxr_q) | rx_new_q;
    assign rx_full  = (rxw_q[AW] != rxr_q[AW])
                    && (rxw_q[AW-1:0] == rxr_q[AW-1:0]);
    assign rx_head  = fu_pkg::fu_rx_entry_t'(rx_head_raw);

    always_comb begin
        st          = '0;
        st.rx_avail = ~rx_empty;
        st.overrun  = ovr_q;
        st.parity   = ~rx_empty & rx_head.parity;
        st.frame    = ~rx_empty & rx_head.frame;
        st.brk      = ~rx_empty & rx_head.brk;
        st.tx_empty = tx_empty;
        st.tx_done  = tx_empty & (tx_st_q == fu_pkg::TX_IDLE);
        st.tx_full  = tx_full;
    end

    always_comb begin
        wr_prev_d = wr_act;
        rd_prev_d = rd_act;
        wr_addr_d = wr_act ? register_address : wr_addr_q;
        wr_data_d = wr_act ? host_data_bus_in : wr_data_q;
        rd_addr_d = rd_addr_q;
        dout_d    = dout_q;
        doe_d     = rd_act;
        drive_disable_out_n_d  = ~rd_act;
        line_d    = line_q;
        div_d     = div_q;
        ctrl_d    = ctrl_q;
        tx_push   = 1'b0;
        rx_pop    = 1'b0;
        tx_clr    = 1'b0;
        rx_clr    = 1'b0;
        if (rd_act && !rd_prev_q) begin
            rd_addr_d = register_address;
            if (register_address == fu_pkg::ADDR_DATA) begin
                dout_d = rx_head.data;
            end else if (register_address == fu_pkg::ADDR_LINE) begin
                dout_d = line_q;
            end else if (register_address == fu_pkg::ADDR_DIV_LO) begin
                dout_d = div_q[7:0];
            end else if (register_address == fu_pkg::ADDR_DIV_HI) begin
                dout_d = div_q[15:8];
            end else if (register_address == fu_pkg::ADDR_CTRL) begin
                dout_d = ctrl_q;
            end else if (register_address == fu_pkg::ADDR_STATUS) begin
                dout_d = st;
            end else begin
                dout_d = 8'h00;
            end
        end
        if (rd_end && rd_addr_q == fu_pkg::ADDR_DATA) begin
            rx_pop = ~rx_empty;
        end
        if (wr_fire) begin
            if (wr_addr_q == fu_pkg::ADDR_DATA) begin
                tx_push = ~tx_full; // full fifo drops the byte
            end else if (wr_addr_q == fu_pkg::ADDR_LINE) begin
                line_d = fu_pkg::fu_line_cfg_t'(wr_data_q);
            end else if (wr_addr_q == fu_pkg::ADDR_DIV_LO) begin
                div_d[7:0] = wr_data_q;
            end else if (wr_addr_q == fu_pkg::ADDR_DIV_HI) begin
                div_d[15:8] = wr_data_q;
            end else if (wr_addr_q == fu_pkg::ADDR_CTRL) begin
                ctrl_d = wr_data_q & fu_pkg::CTRL_KEEP;
                tx_clr = wr_data_q[fu_pkg::CTRL_TX_CLR];
                rx_clr = wr_data_q[fu_pkg::CTRL_RX_CLR];
            end
        end
        // a fresh overrun wins over the clearing status read
        ovr_d = ovr_q;
        if (rd_end && rd_addr_q == fu_pkg::ADDR_STATUS) begin
            ovr_d = 1'b0;
        end
        if (rx_push_req && rx_full) begin
            ovr_d = 1'b1;
        end
    end

    always_comb begin
        txw_d = tx_clr ? txr_q : txw_q + (AW+1)'(tx_push);
        txr_d = txr_q + (AW+1)'(tx_pop);
        rxw_d = rxw_q + (AW+1)'(rx_push);
        rxr_d = rx_clr ? rxw_q : rxr_q + (AW+1)'(rx_pop);
        if (tx_clr) begin
            txr_d = txr_q;
        end
        if (rx_clr) begin
            rxw_d = rxw_q;
        end
        rx_new_d = rx_push && rxw_q[AW-1:0] == rxr_d[AW-1:0];
    end

    fu_fifo_mem #(
        .WIDTH (fu_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (AW)
    ) u_tx_mem (
        .clk_sys (clk_sys),
        .wr_en   (tx_push),
        .wr_addr (txw_q[AW-1:0]),
        .wr_data (wr_data_q),
        .rd_addr (txr_q[AW-1:0]),
        .rd_data (tx_head)
    );

    fu_fifo_mem #(
        .WIDTH (RXW),
        .DEPTH (FIFO_DEPTH),
        .AW    (AW)
    ) u_rx_mem (
        .clk_sys (clk_sys),
        .wr_en   (rx_push),
        .wr_addr (rxw_q[AW-1:0]),
        .wr_data (rx_entry),
        .rd_addr (rxr_d[AW-1:0]),
        .rd_data (rx_head_raw)
    );

    // system clock feeds the divider; divisor 0 behaves as 1
    always_comb begin
        tick_d = 1'b0;
        bcnt_d = bcnt_q - 16'h0001;
        if (bcnt_q == 16'h0000) begin
            tick_d = 1'b1;
            bcnt_d = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
        end
        blow_d = bcnt_q < {1'b0, div_q[15:1]};
    end

    always_comb begin
        tx_st_d    = tx_st_q;
        tx_sub_d   = tx_sub_q;
        tx_bit_d   = tx_bit_q;
        tx_sh_d    = tx_sh_q;
        tx_par_d   = tx_par_q;
        tx_line_d  = tx_line_q;
        tx_stop2_d = tx_stop2_q;
        tx_pop     = 1'b0;
        if (tick_q && tx_st_q != fu_pkg::TX_IDLE
                && tx_st_q != fu_pkg::TX_LOAD) begin
            tx_sub_d = tx_sub_q + 4'h1;
        end
        case (tx_st_q)
            fu_pkg::TX_IDLE: begin
                tx_line_d = 1'b1;
                if (ctrl_q[fu_pkg::CTRL_TX_EN] && !tx_empty) begin
                    tx_st_d = fu_pkg::TX_LOAD;
                end
            end
            fu_pkg::TX_LOAD: begin
                // one cycle lets the registered fifo read settle
                tx_pop    = 1'b1;
                tx_sh_d   = tx_head;
                tx_par_d  = parity_of(tx_head & (8'hff >> len_gap),
                                      line_q.par_even);
                tx_line_d = 1'b0;
                tx_sub_d  = 4'h0;
                tx_st_d   = fu_pkg::TX_START;
            end
            fu_pkg::TX_START: begin
                if (tick_q && tx_sub_q == fu_pkg::SUB_LAST) begin
                    tx_line_d = tx_sh_q[0];
                    tx_bit_d  = 3'h0;
                    tx_st_d   = fu_pkg::TX_DATA;
                end
            end
            fu_pkg::TX_DATA: begin
                if (tick_q && tx_sub_q == fu_pkg::SUB_LAST) begin
                    tx_sh_d  = tx_sh_q >> 1;
                    tx_bit_d = tx_bit_q + 3'h1;
                    tx_line_d = tx_sh_q[1];
                    tx_stop2_d = 1'b0;
                    if (tx_bit_q == last_bit) begin
                        tx_line_d = line_q.par_en ? tx_par_q : 1'b1;
                        tx_st_d = line_q.par_en ? fu_pkg::TX_PARITY
                                                : fu_pkg::TX_STOP;
                    end
                end
            end
            fu_pkg::TX_PARITY: begin
                if (tick_q && tx_sub_q == fu_pkg::SUB_LAST) begin
                    tx_line_d = 1'b1;
                    tx_st_d   = fu_pkg::TX_STOP;
                end
            end
            fu_pkg::TX_STOP: begin
                if (tick_q && tx_sub_q == fu_pkg::SUB_LAST) begin
                    tx_stop2_d = 1'b1;
                    if (!line_q.two_stop || tx_stop2_q) begin
                        tx_st_d = fu_pkg::TX_IDLE;
                    end
                end
            end
            default: tx_st_d = fu_pkg::TX_IDLE;
        endcase
        serial_out_d = tx_line_q;
        if (ctrl_q[fu_pkg::CTRL_LOOP] || !ctrl_q[fu_pkg::CTRL_TX_EN]) begin
            serial_out_d = 1'b1;
        end
    end

    // receiver runs off edges of its own 16x clock pin
    assign rx_tick = receiver_clock_in & ~rxc_q;
    assign rx_line_d = ctrl_q[fu_pkg::CTRL_LOOP]
                     ? tx_line_q : serial_in;
    assign rx_data = rx_sh_q >> len_gap;
    assign rx_push = rx_push_req & ~rx_full;

    always_comb begin
        rx_st_d     = rx_st_q;
        rx_sub_d    = rx_sub_q;
        rx_bit_d    = rx_bit_q;
        rx_sh_d     = rx_sh_q;
        rx_perr_d   = rx_perr_q;
        rx_pbit_d   = rx_pbit_q;
        rx_push_req = 1'b0;
        rx_entry    = '0;
        if (rx_tick) begin
            rx_sub_d = rx_sub_q + 4'h1;
        end
        case (rx_st_q)
            fu_pkg::RX_IDLE: begin
                if (rx_tick && !rx_line_q) begin
                    rx_sub_d = 4'h0;
                    rx_st_d  = fu_pkg::RX_START;
                end
            end
            fu_pkg::RX_START: begin
                if (rx_tick && rx_sub_q == fu_pkg::SUB_MID) begin
                    rx_sub_d  = 4'h0;
                    rx_bit_d  = 3'h0;
                    rx_perr_d = 1'b0;
                    rx_pbit_d = 1'b0;
                    // a high at mid start bit was a glitch
                    rx_st_d = rx_line_q ? fu_pkg::RX_IDLE : fu_pkg::RX_DATA;
                end
            end
            fu_pkg::RX_DATA: begin
                if (rx_tick && rx_sub_q == fu_pkg::SUB_LAST) begin
                    rx_sh_d  = {rx_line_q, rx_sh_q[7:1]};
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == last_bit) begin
                        rx_st_d = line_q.par_en ? fu_pkg::RX_PARITY
                                                : fu_pkg::RX_STOP;
                    end
                end
            end
            fu_pkg::RX_PARITY: begin
                if (rx_tick && rx_sub_q == fu_pkg::SUB_LAST) begin
                    rx_pbit_d = rx_line_q;
                    rx_perr_d = rx_line_q
                              != parity_of(rx_data, line_q.par_even);
                    rx_st_d   = fu_pkg::RX_STOP;
                end
            end
            fu_pkg::RX_STOP: begin
                if (rx_tick && rx_sub_q == fu_pkg::SUB_LAST) begin
                    rx_push_req     = 1'b1;
                    rx_entry.data   = rx_data;
                    rx_entry.parity = rx_perr_q;
                    rx_entry.frame  = ~rx_line_q;
                    rx_entry.brk    = ~rx_line_q && rx_data == 8'h00
                                    && !rx_pbit_q;
                    rx_st_d         = fu_pkg::RX_IDLE;
                end
            end
            default: rx_st_d = fu_pkg::RX_IDLE;
        endcase
        if (!ctrl_q[fu_pkg::CTRL_RX_EN]) begin
            rx_st_d     = fu_pkg::RX_IDLE;
            rx_push_req = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_prev_q  <= 1'b0;
            rd_prev_q  <= 1'b0;
            wr_addr_q  <= 3'h0;
            rd_addr_q  <= 3'h0;
            wr_data_q  <= 8'h00;
            dout_q     <= 8'h00;
            doe_q      <= 1'b0;
            drive_disable_out_n_q   <= 1'b1;
            line_q     <= fu_pkg::fu_line_cfg_t'(fu_pkg::LINE_RST);
            div_q      <= fu_pkg::DIV_RST;
            ctrl_q     <= fu_pkg::CTRL_RST;
            ovr_q      <= 1'b0;
            txw_q      <= '0;
            txr_q      <= '0;
            rxw_q      <= '0;
            rxr_q      <= '0;
            rx_new_q   <= 1'b0;
            bcnt_q     <= 16'h0000;
            tick_q     <= 1'b0;
            blow_q     <= 1'b0;
            tx_st_q    <= fu_pkg::TX_IDLE;
            tx_sub_q   <= 4'h0;
            tx_bit_q   <= 3'h0;
            tx_sh_q    <= 8'h00;
            tx_par_q   <= 1'b0;
            tx_line_q  <= 1'b1;
            tx_stop2_q <= 1'b0;
            serial_out_q     <= 1'b1;
            rx_st_q    <= fu_pkg::RX_IDLE;
            rx_sub_q   <= 4'h0;
            rx_bit_q   <= 3'h0;
            rx_sh_q    <= 8'h00;
            rx_perr_q  <= 1'b0;
            rx_pbit_q  <= 1'b0;
            rxc_q      <= 1'b0;
            rx_line_q  <= 1'b1;
        end else begin
            wr_prev_q  <= wr_prev_d;
            rd_prev_q  <= rd_prev_d;
            wr_addr_q  <= wr_addr_d;
            rd_addr_q  <= rd_addr_d;
            wr_data_q  <= wr_data_d;
            dout_q     <= dout_d;
            doe_q      <= doe_d;
            drive_disable_out_n_q   <= drive_disable_out_n_d;
            line_q     <= line_d;
            div_q      <= div_d;
            ctrl_q     <= ctrl_d;
            ovr_q      <= ovr_d;
            txw_q      <= txw_d;
            txr_q      <= txr_d;
            rxw_q      <= rxw_d;
            rxr_q      <= rxr_d;
            rx_new_q   <= rx_new_d;
            bcnt_q     <= bcnt_d;
            tick_q     <= tick_d;
            blow_q     <= blow_d;
            tx_st_q    <= tx_st_d;
            tx_sub_q   <= tx_sub_d;
            tx_bit_q   <= tx_bit_d;
            tx_sh_q    <= tx_sh_d;
            tx_par_q   <= tx_par_d;
            tx_line_q  <= tx_line_d;
            tx_stop2_q <= tx_stop2_d;
            serial_out_q     <= serial_out_d;
            rx_st_q    <= rx_st_d;
            rx_sub_q   <= rx_sub_d;
            rx_bit_q   <= rx_bit_d;
            rx_sh_q    <= rx_sh_d;
            rx_perr_q  <= rx_perr_d;
            rx_pbit_q  <= rx_pbit_d;
            rxc_q      <= receiver_clock_in;
            rx_line_q  <= rx_line_d;
        end
    end

    assign host_data_bus_out   = dout_q;
    assign host_data_bus_oe    = doe_q;
    assign drive_disable_out_n = drive_disable_out_n_q;
    assign serial_out          = serial_out_q;
    assign baud_out_low        = blow_q;
endmodule // fu_uart
`default_nettype wire

// file: testbench/fu_uart_sva.sv
`default_nettype none
module fu_uart_chk (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       select_a_high,
    input wire logic       select_b_high,
    input wire logic       select_c_low,
    input wire logic       write_strobe_low,
    input wire logic       write_strobe_high,
    input wire logic       read_strobe_low,
    input wire logic       read_strobe_high,
    input wire logic [2:0] register_address,
    input wire logic [7:0] host_data_bus_in,
    input wire logic [7:0] host_data_bus_out,
    input wire logic       host_data_bus_oe,
    input wire logic       drive_disable_out_n,
    input wire logic       serial_in,
    input wire logic       serial_out,
    input wire logic       receiver_clock_in,
    input wire logic       baud_out_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sel;
    logic rd_act;
    logic wr_act;
    assign sel = select_a_high & select_b_high & ~select_c_low;
    assign rd_act = sel & (~read_strobe_low | read_strobe_high);
    assign wr_act = sel & (~write_strobe_low | write_strobe_high);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_read_answer: assert property (rd_act |=> host_data_bus_oe)
        else $error("bus not driven after read");
    chk_read_release: assert property (!rd_act |=> !host_data_bus_oe)
        else $error("bus driven without read");
    chk_drive_disable_out_pair: assert property (
        drive_disable_out_n != host_data_bus_oe)
        else $error("drive disable not matching read drive");
    chk_unsel_quiet: assert property (!sel |=> drive_disable_out_n)
        else $error("unselected strobe answered");
    chk_write_quiet: assert property (
        wr_act && !rd_act |=> !host_data_bus_oe)
        else $error("write drove the bus");
    chk_reset_mark: assert property ($rose(reset_n) |-> serial_out)
        else $error("serial out not mark after reset");
    chk_start_width: assert property (
        $fell(serial_out) |-> !serial_out[*8])
        else $error("start bit too short");
    chk_data_hold: assert property (
        host_data_bus_oe && $past(host_data_bus_oe)
        |-> $stable(host_data_bus_out))
        else $error("read data changed while driven");
endmodule // fu_uart_chk
bind fu_uart fu_uart_chk fu_uart_chk_i (.*);
`default_nettype wire

// file: testbench/fu_line_model.sv
`default_nettype none
module fu_line_model (
    input  wire logic clk_sys,
    input  wire logic hold_space,
    output logic      serial_in,
    output logic      receiver_clock_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       line_q = 1'b1;
    logic [1:0] div_q  = 2'h0;
    // free running 16x clock: one tick per four system cycles
    always @(negedge clk_sys) div_q <= div_q + 2'h1;
    assign receiver_clock_in = div_q[1];
    // a held space shows whether the pin is really cut off in loopback
    assign serial_in = hold_space ? 1'b0 : line_q;
    task automatic bit_out(input logic b);
        line_q = b;
        repeat (64) @(negedge clk_sys);
    endtask
    task automatic send(input logic [7:0] d, input int nb,
                        input logic pe, input logic pb);
        bit_out(1'b0);
        for (int i = 0; i < nb; i++) bit_out(d[i]);
        if (pe) bit_out(pb);
        bit_out(1'b1);
    endtask
endmodule // fu_line_model
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, reset_n, select_a_high, select_b_high, select_c_low;
    logic write_strobe_low, write_strobe_high, read_strobe_low;
    logic read_strobe_high, serial_in, receiver_clock_in, hold_space;
    logic host_data_bus_oe, drive_disable_out_n, serial_out, baud_out_low;
    logic [2:0] register_address;
    logic [7:0] host_data_bus_in, host_data_bus_out, rd_q;
    int   fails, n_compared;
    fu_uart fu_uart_i (.*);
    fu_line_model fu_line_model_i (.*);
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic h);
        @(negedge clk_sys);
        register_address = a;
        host_data_bus_in = d;
        write_strobe_high = h;
        write_strobe_low = h;
        @(negedge clk_sys);
        write_strobe_high = 1'b0;
        write_strobe_low = 1'b1;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] a, input logic h);
        @(negedge clk_sys);
        register_address = a;
        read_strobe_high = h;
        read_strobe_low = h;
        repeat (2) @(negedge clk_sys);
        rd_q = host_data_bus_out;
        cmp({host_data_bus_oe, drive_disable_out_n}, 8'h02);
        read_strobe_high = 1'b0;
        read_strobe_low = 1'b1;
        repeat (2) @(negedge clk_sys);
        cmp({host_data_bus_oe, drive_disable_out_n}, 8'h01);
    endtask
    task automatic wait_rx;
        for (int i = 0; i < 400; i++) begin
            rd(fu_pkg::ADDR_STATUS, 1'b0);
            if (rd_q[0] === 1'b1) return;
        end
        cmp(8'h00, 8'h01);
        end_of_test();
    endtask
    task automatic bit_chk(input logic e);
        cmp({7'h0, serial_out}, {7'h0, e});
        repeat (16) @(negedge clk_sys);
    endtask
    task automatic t_tx(input logic [7:0] ln, input logic [7:0] d);
        int i;
        int nb;
        nb = int'(ln[1:0]) + 5;
        wr(fu_pkg::ADDR_LINE, ln, 1'b0);
        wr(fu_pkg::ADDR_DATA, d, 1'b1);
        for (i = 0; i < 100 && serial_out !== 1'b0; i++) @(negedge clk_sys);
        repeat (8) @(negedge clk_sys);
        bit_chk(1'b0);
        for (i = 0; i < nb; i++) bit_chk(d[i]);
        if (ln[3]) bit_chk(^(d & (8'hff >> (8 - nb))) ^ ~ln[4]);
        bit_chk(1'b1);
    endtask
    task automatic t_rx(input logic [7:0] ln, input logic [7:0] d,
                        input logic bad);
        int nb;
        logic [7:0] m;
        nb = int'(ln[1:0]) + 5;
        m = 8'hff >> (8 - nb);
        wr(fu_pkg::ADDR_LINE, ln, 1'b0);
        fu_line_model_i.send(d & m, nb, ln[3], ^(d & m) ^ ~ln[4] ^ bad);
        wait_rx();
        cmp({6'h0, rd_q[3:2]}, {7'h0, bad});
        rd(fu_pkg::ADDR_DATA, 1'b1);
        cmp(rd_q, d & m);
    endtask
    task automatic t_loop;
        int lows;
        lows = 0;
        wr(fu_pkg::ADDR_DIV_LO, 8'h04, 1'b0);
        wr(fu_pkg::ADDR_LINE, 8'h03, 1'b0);
        wr(fu_pkg::ADDR_CTRL, 8'h07, 1'b1);
        hold_space = 1'b1;
        wr(fu_pkg::ADDR_DATA, 8'h5a, 1'b0);
        repeat (700) begin
            @(negedge clk_sys);
            lows += int'(serial_out !== 1'b1);
        end
        cmp(8'(lows > 0), 8'h00);
        lows = 0;
        repeat (40) begin
            @(negedge clk_sys);
            lows += int'(baud_out_low === 1'b0);
        end
        cmp(8'(lows), 8'h14);
        wait_rx();
        rd(fu_pkg::ADDR_DATA, 1'b0);
        cmp(rd_q, 8'h5a);
        hold_space = 1'b0;
    endtask
    task automatic t_regs;
        cmp({7'h0, serial_out}, 8'h01);
        rd(fu_pkg::ADDR_LINE, 1'b0);
        cmp(rd_q, fu_pkg::LINE_RST);
        wr(fu_pkg::ADDR_LINE, 8'h5b, 1'b1);
        for (int k = 0; k < 3; k++) begin
            {select_a_high, select_b_high, select_c_low} =
                3'b110 ^ (3'h4 >> k);
            wr(fu_pkg::ADDR_LINE, 8'ha4, 1'b0);
            {select_a_high, select_b_high, select_c_low} = 3'b110;
        end
        rd(fu_pkg::ADDR_LINE, 1'b1);
        cmp(rd_q, 8'h5b);
        rd(3'h6, 1'b0);
        cmp(rd_q, 8'h00);
        wr(fu_pkg::ADDR_CTRL, 8'h02, 1'b0);
        wr(fu_pkg::ADDR_DATA, 8'h81, 1'b0);
        rd(fu_pkg::ADDR_STATUS, 1'b1);
        cmp({6'h0, rd_q[6:5]}, 8'h00);
        cmp({7'h0, serial_out}, 8'h01);
        wr(fu_pkg::ADDR_CTRL, 8'h0b, 1'b0);
        rd(fu_pkg::ADDR_STATUS, 1'b1);
        cmp({6'h0, rd_q[6:5]}, 8'h03);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        {reset_n, write_strobe_high, read_strobe_high, hold_space} = 4'h0;
        {select_a_high, select_b_high, select_c_low} = 3'b110;
        {write_strobe_low, read_strobe_low} = 2'h3;
        register_address = 3'h0;
        host_data_bus_in = 8'h00;
        fails = 0;
        n_compared = 0;
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        t_regs();
        t_tx(8'h03, 8'ha6);
        t_tx(8'h18, 8'h13);
        t_tx(8'h0a, 8'h35);
        t_rx(8'h19, 8'h2c, 1'b0);
        t_rx(8'h0b, 8'h9e, 1'b1);
        t_loop();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
